// *** core/sws_status_regs.sv ***
// switch status register upper half (bits 15..31) with an APB slave
// assumes: presetn is fundamental reset; hot reset arrives as a pulse or via control reg
// Overview of operation
// - bits 15-19 show straps captured at fundamental reset
// - bits 22:20 show live lock owner, reset zero
// - lock code zero unlocked, else port 1-14
// - bits 31:28 software scratch, reset zero
// - scratch survives hot reset, fundamental clears
`timescale 1ns/1ps
`include "sws_cfg.svh"
module sws_status_regs #(
    parameter int ADDR_W = `SWS_ADDR_W
) (
    // clock and fundamental reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire sws_pkg::sws_apb_req_t apb_req,
    output sws_pkg::sws_apb_rsp_t      apb_rsp,
    // hot reset request from switch reset sequencer
    input  wire logic                  hot_reset,
    // port-pair join straps 6/7, 8/9, 10/11, 12/13, 14/15
    input  wire logic                  pair_6_7_join_strap,
    input  wire logic                  pair_8_9_join_strap,
    input  wire logic                  pair_10_11_join_strap,
    input  wire logic                  pair_12_13_join_strap,
    input  wire logic                  pair_14_15_join_strap,
    // lock tracker: valid flag and port number
    input  wire logic                  lock_active,
    input  wire logic [3:0]            lock_port,
    // field views for the rest of the switch
    output logic [`SWS_MARK_W-1:0]     marker,
    output logic [`SWS_LOCK_W-1:0]     upstream_lock_owner
);
    import sws_pkg::*;

    logic [`SWS_STRAP_N-1:0] strap_held;
    logic                    strap_done;
    logic [`SWS_LOCK_SRC_W-1:0] lock_full;
    logic [31:0]             rdata_q;
    logic                    hot_req;

    // register select, shared by every offset compare
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

    // apb decode
    wire setup      = apb_req.psel && !apb_req.penable;
    wire access     = apb_req.psel && apb_req.penable;
    wire wr_acc     = access && apb_req.pwrite;
    wire hit_status = reg_hit(apb_req.paddr, `SWS_STATUS_OFS);
    wire hit_ctrl   = reg_hit(apb_req.paddr, `SWS_CTRL_OFS);
    wire hit_lock   = reg_hit(apb_req.paddr, `SWS_LOCK_OFS);
    wire mapped     = hit_status || hit_ctrl || hit_lock;
    wire wr_mark    = wr_acc && hit_status && apb_req.pstrb[3];
    wire wr_ctrl    = wr_acc && hit_ctrl && apb_req.pstrb[0];
    wire sw_hot     = wr_ctrl && apb_req.pwdata[`SWS_CTRL_HOT_BIT];
    wire any_hot    = hot_reset || sw_hot;

    sws_strap_capture #(
        .N(`SWS_STRAP_N)
    ) u_cap (
        .pclk      (pclk),
        .presetn   (presetn),
        .strap_in  ({pair_14_15_join_strap, pair_12_13_join_strap, pair_10_11_join_strap,
                     pair_8_9_join_strap, pair_6_7_join_strap}),
        .strap_held(strap_held),
        .captured  (strap_done)
    );

    // lock code: zero when unlocked, else port 1..14, other values fold to zero
    wire lock_ok = lock_active && (lock_port != 4'h0) && (lock_port <= `SWS_LOCK_MAX);
    wire [`SWS_LOCK_SRC_W-1:0] next_lock = lock_ok ? lock_port : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_full <= 4'h0;
        end else if (any_hot) begin
            lock_full <= 4'h0;
        end else begin
            lock_full <= next_lock;
        end
    end

    // field holds only three bits; codes above 7 show their low bits
    assign upstream_lock_owner = lock_full[`SWS_LOCK_W-1:0];

    // marker: only fundamental reset clears; hot reset leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            marker <= `SWS_MARK_RST;
        end else if (wr_mark) begin
            marker <= apb_req.pwdata[`SWS_MARK_MSB:`SWS_MARK_LSB];
        end
    end

    // read mux; reserved bits and bits below 15 read zero
    wire [31:0] status_word = {marker, 5'h00, upstream_lock_owner, strap_held, 15'h0000};
    wire [31:0] ctrl_word   = {30'h0, strap_done, 1'b0};
    wire [31:0] lock_word   = {28'h0000000, lock_full};
    wire [31:0] next_rdata  = hit_status ? status_word :
                              hit_ctrl   ? ctrl_word   :
                              hit_lock   ? lock_word   : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            hot_req <= 1'b0;
        end else begin
            hot_req <= any_hot;
            if (setup && !apb_req.pwrite) begin
                rdata_q <= next_rdata;
            end
        end
    end

    assign apb_rsp.prdata  = rdata_q;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access && !mapped;

    // marker holds across a hot reset unless written in that cycle
    property p_mark_hot;
        @(posedge pclk) disable iff (!presetn)
        any_hot && !wr_mark |=> $stable(marker);
    endproperty
    a_mark_hot: assert property (p_mark_hot) else $error("marker lost on hot reset");

    property p_mark_write;
        @(posedge pclk) disable iff (!presetn)
        wr_mark |=> marker == $past(apb_req.pwdata[31:28]);
    endproperty
    a_mark_write: assert property (p_mark_write) else $error("marker write not stored");

    property p_mark_idle;
        @(posedge pclk) disable iff (!presetn)
        !wr_mark |=> $stable(marker);
    endproperty
    a_mark_idle: assert property (p_mark_idle) else $error("marker changed without write");

    sequence s_lock_seen;
        !any_hot && lock_active && lock_port >= 4'h1 && lock_port <= 4'h7;
    endsequence
    property p_lock_track;
        @(posedge pclk) disable iff (!presetn)
        s_lock_seen |=> upstream_lock_owner == $past(lock_port[2:0]);
    endproperty
    a_lock_track: assert property (p_lock_track) else $error("lock owner not tracked");

    property p_lock_free;
        @(posedge pclk) disable iff (!presetn)
        !lock_active |=> upstream_lock_owner == 3'h0;
    endproperty
    a_lock_free: assert property (p_lock_free) else $error("unlocked not shown as zero");

    property p_lock_range;
        @(posedge pclk) disable iff (!presetn)
        lock_full <= `SWS_LOCK_MAX;
    endproperty
    a_lock_range: assert property (p_lock_range) else $error("lock code out of range");

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        setup && !apb_req.pwrite && hit_status |=> rdata_q[27:23] == 5'h00 && rdata_q[14:0] == 15'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_strap_read;
        @(posedge pclk) disable iff (!presetn)
        setup && !apb_req.pwrite && hit_status |=> rdata_q[19:15] == $past(strap_held);
    endproperty
    a_strap_read: assert property (p_strap_read) else $error("strap bits misread");

    property p_ro_write;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && hit_status && strap_done && $past(strap_done) |=> $stable(strap_held);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only bits took a write");

    // read cycles: the setup edge loads rdata_q, checked one edge later
    sequence s_status_rd;
        setup && !apb_req.pwrite && hit_status;
    endsequence
    sequence s_lock_rd;
        setup && !apb_req.pwrite && hit_lock;
    endsequence
    sequence s_ctrl_rd;
        setup && !apb_req.pwrite && hit_ctrl;
    endsequence
    sequence s_stray_rd;
        setup && !apb_req.pwrite && !mapped;
    endsequence

    property p_mark_read;
        @(posedge pclk) disable iff (!presetn)
        s_status_rd |=> rdata_q[`SWS_MARK_MSB:`SWS_MARK_LSB] == $past(marker);
    endproperty
    a_mark_read: assert property (p_mark_read) else $error("scratch field misread");

    property p_owner_read;
        @(posedge pclk) disable iff (!presetn)
        s_status_rd |=> rdata_q[`SWS_LOCK_MSB:`SWS_LOCK_LSB] == $past(upstream_lock_owner);
    endproperty
    a_owner_read: assert property (p_owner_read) else $error("lock field misread");

    // one read-back check per port-pair strap bit
    for (genvar g = 0; g < `SWS_STRAP_N; g++) begin : g_strap_bit
        property p_strap_bit;
            @(posedge pclk) disable iff (!presetn)
            s_status_rd |=> rdata_q[`SWS_STRAP_LSB + g] == $past(strap_held[g]);
        endproperty
        a_strap_bit: assert property (p_strap_bit) else $error("strap bit misread");
    end

    property p_lock_word;
        @(posedge pclk) disable iff (!presetn)
        s_lock_rd |=> rdata_q[31:`SWS_LOCK_SRC_W] == '0 && rdata_q[`SWS_LOCK_SRC_W-1:0] == $past(lock_full);
    endproperty
    a_lock_word: assert property (p_lock_word) else $error("full lock code misread");

    property p_ctrl_word;
        @(posedge pclk) disable iff (!presetn)
        s_ctrl_rd |=> rdata_q[`SWS_CTRL_CAP_BIT] == $past(strap_done) && !rdata_q[`SWS_CTRL_HOT_BIT];
    endproperty
    a_ctrl_word: assert property (p_ctrl_word) else $error("capture flag misread");

    property p_stray_rd;
        @(posedge pclk) disable iff (!presetn)
        s_stray_rd |=> rdata_q == 32'h00000000;
    endproperty
    a_stray_rd: assert property (p_stray_rd) else $error("unmapped read not zero");

    // read data stands until the next read setup
    property p_rd_stand;
        @(posedge pclk) disable iff (!presetn)
        !(setup && !apb_req.pwrite) |=> $stable(rdata_q);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved without a read");

    // hot reset empties the lock code one edge later, for as many cycles as it is held
    property p_lock_hot;
        @(posedge pclk) disable iff (!presetn)
        hot_req |-> lock_full == 4'h0;
    endproperty
    a_lock_hot: assert property (p_lock_hot) else $error("lock code survived hot reset");

    property p_lock_clear;
        @(posedge pclk) disable iff (!presetn)
        any_hot |=> lock_full == 4'h0;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock code not cleared by hot reset");

    sequence s_lock_high;
        !any_hot && lock_active && lock_port > 4'h7 && lock_port <= `SWS_LOCK_MAX;
    endsequence
    property p_lock_high;
        @(posedge pclk) disable iff (!presetn)
        s_lock_high |=> lock_full == $past(lock_port);
    endproperty
    a_lock_high: assert property (p_lock_high) else $error("upper lock code not kept");

    sequence s_lock_bad;
        !any_hot && lock_active && (lock_port == 4'h0 || lock_port > `SWS_LOCK_MAX);
    endsequence
    property p_lock_bad;
        @(posedge pclk) disable iff (!presetn)
        s_lock_bad |=> lock_full == 4'h0;
    endproperty
    a_lock_bad: assert property (p_lock_bad) else $error("invalid lock port not shown as zero");

    property p_mark_strobe;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && hit_status && !apb_req.pstrb[3] |=> $stable(marker);
    endproperty
    a_mark_strobe: assert property (p_mark_strobe) else $error("scratch written without its strobe");

    property p_mark_other;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && !hit_status |=> $stable(marker);
    endproperty
    a_mark_other: assert property (p_mark_other) else $error("scratch moved on other register write");

    property p_status_wr_lock;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && hit_status && !any_hot |=> lock_full == $past(next_lock);
    endproperty
    a_status_wr_lock: assert property (p_status_wr_lock) else $error("status write disturbed lock code");

    property p_ctrl_quiet;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && !sw_hot && !hot_reset |=> lock_full == $past(next_lock);
    endproperty
    a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("plain control write moved lock code");

    property p_cap_zero;
        @(posedge pclk) disable iff (!presetn)
        !strap_done |-> strap_held == '0;
    endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("strap copy nonzero before capture");

    property p_cap_sticky;
        @(posedge pclk) disable iff (!presetn)
        strap_done |=> strap_done;
    endproperty
    a_cap_sticky: assert property (p_cap_sticky) else $error("capture flag dropped without reset");

    property p_strap_hot;
        @(posedge pclk) disable iff (!presetn)
        any_hot && strap_done |=> $stable(strap_held);
    endproperty
    a_strap_hot: assert property (p_strap_hot) else $error("hot reset changed strap copy");
endmodule : sws_status_regs

// *** pkg/sws_cfg.svh ***
// register layout, reset values and widths for the switch status upper fields
// assumes: included by bare name from the package and the design files
`ifndef SWS_CFG_SVH
`define SWS_CFG_SVH

`define SWS_ADDR_W          12
`define SWS_STATUS_OFS      12'h000
`define SWS_CTRL_OFS        12'h004
`define SWS_LOCK_OFS        12'h008
`define SWS_STRAP_LSB       15
`define SWS_STRAP_MSB       19
`define SWS_STRAP_N         5
`define SWS_LOCK_LSB        20
`define SWS_LOCK_MSB        22
`define SWS_LOCK_W          3
`define SWS_RSVD_LSB        23
`define SWS_RSVD_MSB        27
`define SWS_MARK_LSB        28
`define SWS_MARK_MSB        31
`define SWS_MARK_W          4
`define SWS_MARK_RST        4'h0
`define SWS_LOCK_RST        3'h0
`define SWS_LOCK_SRC_W      4
`define SWS_LOCK_MAX        4'hE
`define SWS_CTRL_HOT_BIT    0
`define SWS_CTRL_CAP_BIT    1

`endif

// *** pkg/sws_pkg.sv ***
// types shared by the switch status upper fields block
// assumes: sws_cfg.svh gives widths and offsets
`include "sws_cfg.svh"
package sws_pkg;
    typedef struct packed {
        logic [`SWS_ADDR_W-1:0] paddr;
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [31:0]            pwdata;
        logic [3:0]             pstrb;
    } sws_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sws_apb_rsp_t;

    typedef enum logic [1:0] {
        SWS_CAP_WAIT = 2'h0,
        SWS_CAP_TAKE = 2'h1,
        SWS_CAP_DONE = 2'h3
    } sws_cap_state_t;
endpackage : sws_pkg

// *** core/sws_strap_capture.sv ***
// latches the port-pair join straps once, right after fundamental reset release
// assumes: straps are steady and synchronous to pclk while reset is asserted
`timescale 1ns/1ps
`include "sws_cfg.svh"
module sws_strap_capture #(
    parameter int N = `SWS_STRAP_N
) (
    // clock and fundamental reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // strap levels and captured copy
    input  wire logic [N-1:0] strap_in,
    output logic      [N-1:0] strap_held,
    output logic              captured
);
    import sws_pkg::*;

    sws_cap_state_t state;
    sws_cap_state_t next_state;
    wire            take = (state == SWS_CAP_TAKE);

    always_comb begin
        unique case (state)
            SWS_CAP_WAIT: next_state = SWS_CAP_TAKE;
            SWS_CAP_TAKE: next_state = SWS_CAP_DONE;
            SWS_CAP_DONE: next_state = SWS_CAP_DONE;
            default:      next_state = SWS_CAP_DONE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= SWS_CAP_WAIT;
            strap_held <= '0;
        end else begin
            state <= next_state;
            if (take) begin
                strap_held <= strap_in;
            end
        end
    end

    assign captured = (state == SWS_CAP_DONE);

    property p_strap_hold;
        @(posedge pclk) disable iff (!presetn)
        captured && $past(captured) |-> $stable(strap_held);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap copy changed after capture");

    property p_strap_take;
        @(posedge pclk) disable iff (!presetn)
        take |=> strap_held == $past(strap_in);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap not captured");
endmodule : sws_strap_capture

// *** tb/sws_status_regs_bench.sv ***
// self-checking bench for the switch status upper fields, driven over APB
// assumes: sws_pkg and the design are compiled first; slave answers with zero wait states
`timescale 1ns/1ps
`include "sws_cfg.svh"
module sws_status_regs_bench;
    import sws_pkg::*;
    localparam logic [31:0] MASK = 32'hFFFF8000;
    logic         pclk;
    logic         presetn;
    sws_apb_req_t req;
    sws_apb_rsp_t rsp;
    logic         hot_reset;
    logic [4:0]   stp;
    logic         lock_active;
    logic [3:0]   lock_port;
    logic [3:0]   marker;
    logic [2:0]   owner;
    logic [31:0]  rd;
    logic         err;
    logic [3:0]   code;
    int           err_count;
    int           total_checks;

    sws_status_regs i_dut (
        .pclk                  (pclk),
        .presetn               (presetn),
        .apb_req               (req),
        .apb_rsp               (rsp),
        .hot_reset             (hot_reset),
        .pair_6_7_join_strap   (stp[0]),
        .pair_8_9_join_strap   (stp[1]),
        .pair_10_11_join_strap (stp[2]),
        .pair_12_13_join_strap (stp[3]),
        .pair_14_15_join_strap (stp[4]),
        .lock_active           (lock_active),
        .lock_port             (lock_port),
        .marker                (marker),
        .upstream_lock_owner   (owner)
    );

    // expected upper half: scratch, reserved zero, lock field, straps
    function automatic logic [31:0] st(input logic [3:0] m, input logic [2:0] l, input logic [4:0] s);
        return {m, 5'h00, l, s, 15'h0000};
    endfunction : st

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk32

    // one transfer; called right after a rising edge, returns right after one
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        req.paddr   <= a;
        req.pwrite  <= wr;
        req.pwdata  <= d;
        req.pstrb   <= s;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_status(input string what, input logic [31:0] exp);
        apb(1'b0, `SWS_STATUS_OFS, 32'h0, 4'h0);
        chk32(what, exp, rd & MASK);
    endtask : rd_status

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        wrap_up();
    end

    initial begin
        req = '0;
        presetn = 1'b0;
        hot_reset = 1'b0;
        stp = 5'h16;
        lock_active = 1'b0;
        lock_port = 4'h0;
        err_count = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        // strap levels moving after capture must not show
        stp <= 5'h09;
        rd_status("status after reset", st(4'h0, 3'h0, 5'h16));
        apb(1'b0, `SWS_CTRL_OFS, 32'h0, 4'h0);
        chk32("strap capture flag", 32'h1 << `SWS_CTRL_CAP_BIT, rd);
        apb(1'b1, `SWS_STATUS_OFS, 32'hFFFFFFFF, 4'hF);
        rd_status("status after all ones", st(4'hF, 3'h0, 5'h16));
        apb(1'b1, `SWS_STATUS_OFS, 32'h00000000, 4'h7);
        rd_status("scratch without top strobe", st(4'hF, 3'h0, 5'h16));
        apb(1'b1, `SWS_STATUS_OFS, 32'h00000000, 4'hF);
        rd_status("scratch cleared", st(4'h0, 3'h0, 5'h16));
        for (int p = 0; p < 16; p++) begin
            lock_active <= 1'b1;
            lock_port <= 4'(p);
            repeat (3) @(posedge pclk);
            code = (p >= 1 && p <= 14) ? 4'(p) : 4'h0;
            chk32("lock owner port", {29'h0, code[2:0]}, {29'h0, owner});
            rd_status("status lock field", st(4'h0, code[2:0], 5'h16));
            apb(1'b0, `SWS_LOCK_OFS, 32'h0, 4'h0);
            chk32("full lock code", {28'h0, code}, rd);
        end
        lock_active <= 1'b0;
        repeat (3) @(posedge pclk);
        rd_status("status unlocked", st(4'h0, 3'h0, 5'h16));
        apb(1'b1, `SWS_STATUS_OFS, 32'hA0000000, 4'hF);
        hot_reset <= 1'b1;
        @(posedge pclk);
        hot_reset <= 1'b0;
        @(posedge pclk);
        rd_status("scratch over hot reset", st(4'hA, 3'h0, 5'h16));
        chk32("scratch port", 32'hA, {28'h0, marker});
        apb(1'b1, `SWS_CTRL_OFS, 32'h00000001, 4'hF);
        rd_status("scratch over soft hot reset", st(4'hA, 3'h0, 5'h16));
        apb(1'b1, 12'h010, 32'hFFFFFFFF, 4'hF);
        chk32("unmapped error flag", 32'h1, {31'h0, err});
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        chk32("unmapped read data", 32'h0, rd);
        chk32("unmapped read error", 32'h1, {31'h0, err});
        rd_status("status after unmapped write", st(4'hA, 3'h0, 5'h16));
        stp <= 5'h0B;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rd_status("status after second reset", st(4'h0, 3'h0, 5'h0B));
        wrap_up();
    end
endmodule : sws_status_regs_bench
